// file: rtl/ddi_input_block.sv
// Debounced digital input channels with AXI4-Lite register access
`default_nettype none
module ddi_input_block #(
  parameter int NUM_CH = 8
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [NUM_CH-1:0] field_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic irq_out
);
  localparam int SW = ddi_pkg::DDI_SCAN_W;

  // Byte-lane merge of a write into a 32-bit register
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Pin synchroniser, two stages; stage one read only by stage two
  logic [NUM_CH-1:0] sync1_q;
  logic [NUM_CH-1:0] sync2_q;
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= field_in;
      sync2_q <= sync1_q;
    end
  end

  // Software state
  logic [31:0] ctrl_q; // Mode and invert fields
  logic [NUM_CH-1:0] stat_q; // Sticky event flags
  logic [NUM_CH-1:0] mask_q; // Interrupt enables
  logic [SW-1:0] scan_q [NUM_CH]; // Scan intervals per channel
  // Channel state
  logic [NUM_CH-1:0] level_q; // Accepted logical level
  logic [NUM_CH-1:0] pend_q; // Pending edge events
  logic [NUM_CH-1:0] evt; // Accepted edge this cycle
  logic [NUM_CH-1:0] rd_clr; // Host read of value register
  logic [NUM_CH-1:0] wr_stat_clr; // W1C of status

  // AXI write path: address and data caught in either order
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  assign s_axi_awready_out = !aw_hold_q && !bvalid_q;
  assign s_axi_wready_out = !w_hold_q && !bvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // Capture write address and data, then answer once both are held
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= ddi_pkg::DDI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known(awaddr_q) ? ddi_pkg::DDI_RESP_OKAY
                                      : ddi_pkg::DDI_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Writable offsets; scan registers follow channel zero
  function automatic logic wr_known(input logic [7:0] a);
    logic ok;
    ok = (a == ddi_pkg::DDI_OFF_CTRL) || (a == ddi_pkg::DDI_OFF_STAT) ||
         (a == ddi_pkg::DDI_OFF_MASK) || is_scan(a);
    return ok;
  endfunction : wr_known

  // True when the address hits a scan interval register
  function automatic logic is_scan(input logic [7:0] a);
    logic ok;
    ok = (a >= ddi_pkg::DDI_OFF_SCAN0) && (a[1:0] == 2'h0) &&
         (a < ddi_pkg::DDI_OFF_SCAN0 + 8'(NUM_CH * 4));
    return ok;
  endfunction : is_scan

  // Control and mask registers; scan intervals are written in the channel loop
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ctrl_q <= ddi_pkg::DDI_CTRL_RST;
      mask_q <= '0;
    end else if (wr_fire) begin
      if (awaddr_q == ddi_pkg::DDI_OFF_CTRL) begin
        ctrl_q <= wmerge(ctrl_q, wdata_q, wstrb_q);
      end
      if (awaddr_q == ddi_pkg::DDI_OFF_MASK) begin
        mask_q <= NUM_CH'(wmerge(32'(mask_q), wdata_q, wstrb_q));
      end
    end
  end

  // Status write-one-to-clear decode
  always_comb begin
    wr_stat_clr = '0;
    if (wr_fire && awaddr_q == ddi_pkg::DDI_OFF_STAT) begin
      wr_stat_clr = NUM_CH'(wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}});
    end
  end

  // AXI read path
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rd_fire;
  assign s_axi_arready_out = !rvalid_q;
  assign rd_fire = s_axi_arvalid_in && !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // Channel value word: 01 or 00 per channel, in its own bit
  logic [NUM_CH-1:0] value_vec;

  // Answer a read one cycle after the address is taken
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= ddi_pkg::DDI_ZERO;
      rresp_q <= ddi_pkg::DDI_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= ddi_pkg::DDI_RESP_OKAY;
      if (s_axi_araddr_in == ddi_pkg::DDI_OFF_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (s_axi_araddr_in == ddi_pkg::DDI_OFF_VALUE) begin
        rdata_q <= 32'(value_vec);
      end else if (s_axi_araddr_in == ddi_pkg::DDI_OFF_STAT) begin
        rdata_q <= 32'(stat_q);
      end else if (s_axi_araddr_in == ddi_pkg::DDI_OFF_MASK) begin
        rdata_q <= 32'(mask_q);
      end else if (s_axi_araddr_in == ddi_pkg::DDI_OFF_LEVEL) begin
        rdata_q <= 32'(level_q);
      end else if (is_scan(s_axi_araddr_in)) begin
        rdata_q <= 32'(scan_q[3'(
          (s_axi_araddr_in - ddi_pkg::DDI_OFF_SCAN0) >> 2)]);
      end else begin
        // Unmapped: error answer, zero data
        rdata_q <= ddi_pkg::DDI_ZERO;
        rresp_q <= ddi_pkg::DDI_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // A value read clears pending events of every edge-mode channel
  assign rd_clr = (rd_fire && s_axi_araddr_in == ddi_pkg::DDI_OFF_VALUE)
                  ? '1 : '0;

  // One conditioning path per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    ddi_pkg::ddi_cfg_s cfg;
    logic logic_in;
    logic [SW-1:0] tmr_q; // Stability timer
    logic busy_q; // Timer running
    assign cfg.invert = ctrl_q[c*ddi_pkg::DDI_CTRL_STRIDE +
                               ddi_pkg::DDI_CTRL_INV_BIT];
    assign cfg.mode = ddi_pkg::ddi_mode_e'(ctrl_q[c*ddi_pkg::DDI_CTRL_STRIDE +
                               ddi_pkg::DDI_CTRL_MODE_LSB +: 2]);
    // Inversion ahead of the filter, so every mode sees it
    assign logic_in = sync2_q[c] ^ cfg.invert;

    // Scan interval per channel, written by the host
    always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
        scan_q[c] <= ddi_pkg::DDI_SCAN_RST;
      end else if (wr_fire && is_scan(awaddr_q) &&
                   3'((awaddr_q - ddi_pkg::DDI_OFF_SCAN0) >> 2) == 3'(c)) begin
        scan_q[c] <= SW'(wdata_q);
      end
    end

    // Stability filter: a change starts the timer, a return cancels it
    always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
        level_q[c] <= 1'b0;
        busy_q <= 1'b0;
        tmr_q <= '0;
      end else if (logic_in == level_q[c]) begin
        busy_q <= 1'b0; // Short pulse dropped
        tmr_q <= '0;
      end else if (!busy_q) begin
        busy_q <= 1'b1;
        tmr_q <= SW'(1);
      end else if (tmr_q >= scan_q[c]) begin
        level_q[c] <= logic_in;
        busy_q <= 1'b0;
        tmr_q <= '0;
      end else begin
        tmr_q <= tmr_q + SW'(1);
      end
    end

    // Accepted transition of the selected direction; count mode unused here
    always_comb begin
      evt[c] = 1'b0;
      if (busy_q && logic_in != level_q[c] && tmr_q >= scan_q[c]) begin
        evt[c] = (cfg.mode == ddi_pkg::DDI_MODE_RISE && logic_in) ||
                 (cfg.mode == ddi_pkg::DDI_MODE_FALL && !logic_in);
      end
    end

    // Pending flag: set beats the read clear
    always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
        pend_q[c] <= 1'b0;
      end else if (evt[c]) begin
        pend_q[c] <= 1'b1;
      end else if (rd_clr[c]) begin
        pend_q[c] <= 1'b0;
      end
    end

    // Sticky status flag: set beats the W1C clear
    always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
        stat_q[c] <= 1'b0;
      end else if (evt[c]) begin
        stat_q[c] <= 1'b1;
      end else if (wr_stat_clr[c]) begin
        stat_q[c] <= 1'b0;
      end
    end

    // Read value: level in reflect, pending flag in edge modes
    assign value_vec[c] = (cfg.mode == ddi_pkg::DDI_MODE_REFLECT) ?
                          level_q[c] :
                          (cfg.mode == ddi_pkg::DDI_MODE_COUNT) ? 1'b0 :
                          pend_q[c];
  end

  // Level interrupt while any unmasked event flag is set
  assign irq_out = |(stat_q & mask_q);
endmodule : ddi_input_block
`default_nettype wire

// file: rtl/ddi_pkg.sv
// Package: register map, field layouts, modes and carriers for the input block
// Notes on behaviour
// - Each channel runs its own selectable mode
// - Only stable filtered input is ever evaluated
// - Inversion makes logical level the physical complement
// - Inversion applies in all four modes
// - Reflect mode returns filtered logical level
// - Edge starts timer; accept if stable throughout
// - Timer expiry with stable input captures level
// - Pulses shorter than interval are discarded
// - Return to old level stops the timer
// - Scan interval programmable per channel by host
// - Scan interval sets minimum detectable pulse width
// - Rising reacts low-high only, falling high-low
// - Rising event recorded only after stable high
// - Selected edge sets channel value to one
// - Pending event held until host reads channel
// - Reflect read returns 00 low, 01 high
// - Edge read returns 01 pending, 00 none
`default_nettype none
package ddi_pkg;
  // Channel operating modes, two-bit field
  typedef enum logic [1:0] {
    DDI_MODE_REFLECT = 2'h0,
    DDI_MODE_RISE = 2'h1,
    DDI_MODE_FALL = 2'h2,
    DDI_MODE_COUNT = 2'h3
  } ddi_mode_e;
  // Register byte offsets
  localparam logic [7:0] DDI_OFF_CTRL = 8'h00; // Mode and invert per channel
  localparam logic [7:0] DDI_OFF_VALUE = 8'h04; // Channel values, read clears
  localparam logic [7:0] DDI_OFF_STAT = 8'h08; // Sticky event status, W1C
  localparam logic [7:0] DDI_OFF_MASK = 8'h0C; // Interrupt mask
  localparam logic [7:0] DDI_OFF_LEVEL = 8'h10; // Filtered logical levels
  localparam logic [7:0] DDI_OFF_SCAN0 = 8'h20; // Scan interval, channel 0
  // Control field layout: 4 bits per channel
  localparam int DDI_CTRL_STRIDE = 4;
  localparam int DDI_CTRL_MODE_LSB = 0;
  localparam int DDI_CTRL_INV_BIT = 2;
  // Scan interval register width in bits; the interval counts clock cycles
  localparam int DDI_SCAN_W = 24;
  localparam logic [23:0] DDI_SCAN_RST = 24'h000001;
  // Reset values
  localparam logic [31:0] DDI_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DDI_ZERO = 32'h0000_0000;
  // AXI response codes
  localparam logic [1:0] DDI_RESP_OKAY = 2'h0;
  localparam logic [1:0] DDI_RESP_SLVERR = 2'h2;
  // Per-channel configuration carrier
  typedef struct packed {
    logic invert;
    ddi_mode_e mode;
  } ddi_cfg_s;
endpackage : ddi_pkg
`default_nettype wire

// file: tb/ddi_chk.sv
// Checker: bus handshake and reset properties at the block's ports
`default_nettype none
module ddi_chk (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Steps of a read: taken, then waiting on the host
  sequence s_ar_take;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid_out && !s_axi_rready_in;
  endsequence
  // Steps of a write: both halves taken at one edge
  sequence s_w_take;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out;
  endsequence
  AST_R_LAT: assert property (s_ar_take |=> s_axi_rvalid_out)
    else $error("read not answered");
  AST_R_HOLD: assert property (s_r_wait |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("rdata moved");
  AST_AR_BLOCK: assert property (s_axi_rvalid_out |->
    !s_axi_arready_out) else $error("read taken while busy");
  AST_B_LAT: assert property (s_w_take |-> ##[1:2] s_axi_bvalid_out)
    else $error("write not answered");
  AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("bresp moved");
  AST_B_DROP: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
    !s_axi_bvalid_out) else $error("bvalid stuck");
  AST_RST_IRQ: assert property (disable iff (1'b0)
    !reset_n_in |=> !irq_out) else $error("irq set after reset");
  AST_RST_VLD: assert property (disable iff (1'b0) !reset_n_in |=>
    !s_axi_bvalid_out && !s_axi_rvalid_out) else $error("valid in reset");
endmodule : ddi_chk
bind ddi_input_block ddi_chk i_chk (.sys_clk_in, .reset_n_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .irq_out);
`default_nettype wire

// file: tb/ddi_field_model.sv
// Field-side model: steps or pulses one raw input line on request
`default_nettype none
module ddi_field_model (
  input wire logic clk_in,
  input wire logic go_in, // Start a step or a pulse
  input wire logic [2:0] ch_in, // Line to move
  input wire logic [7:0] width_in, // Pulse width, zero for a step
  output logic [7:0] field_out // Raw physical lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00; // Cycles left in a pulse
  logic [2:0] ch_q = 3'h0; // Line held by the running pulse
  initial field_out = 8'h00;
  // One pulse at a time; a new request takes over the counter
  always @(posedge clk_in) begin
    if (go_in) begin
      ch_q <= ch_in;
      cnt_q <= width_in;
      field_out[ch_in] <= ~field_out[ch_in];
    end else if (cnt_q == 8'h01) begin // Glitch ends
      field_out[ch_q] <= ~field_out[ch_q];
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : ddi_field_model
`default_nettype wire

// file: tb/tb_top.sv
// Testbench: register host, field stimulus and read checks
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  err_count++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr_, bv, arr, rv, irq;
  logic [1:0] bresp, rresp;
  logic [2:0] ch = 3'h0;
  logic [7:0] wid = 8'h00, aw = 8'h00, ar = 8'h00, fld;
  logic [31:0] wd = 32'h0, rdata;
  logic [33:0] exp_q[$], got_e; // Expected response and data
  int err_count = 0, checks_done = 0, cyc = 0;
  ddi_input_block i_dut (.sys_clk_in(clk), .reset_n_in(rst_n),
    .field_in(fld), .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ar),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .irq_out(irq));
  ddi_field_model i_fld (.clk_in(clk), .go_in(go), .ch_in(ch),
    .width_in(wid), .field_out(fld));
  initial begin
    forever #2 clk = ~clk;
  end
  // Write: both halves offered together, each dropped once taken
  // Handshakes are judged on values settled at the falling edge, which
  // still stand at the next rising edge; reading combinational readies
  // right after the rising edge would race with the slave's own update
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic a_t;
    logic w_t;
    logic b_t;
    logic [1:0] rs_t;
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(negedge clk);
      a_t = awv && (awr === 1'b1);
      w_t = wv && (wr_ === 1'b1);
      b_t = (bv === 1'b1);
      rs_t = bresp;
      @(posedge clk);
      if (a_t) awv <= 1'b0;
      if (w_t) wv <= 1'b0;
    end while (!b_t);
    br <= 1'b0;
    `CHK(rs_t, ddi_pkg::DDI_RESP_OKAY)
  endtask : wr
  // Read: expectation noted, the monitor compares the answer
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    logic a_t;
    logic r_t;
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    exp_q.push_back({r, d});
    do begin
      @(negedge clk);
      a_t = arv && (arr === 1'b1);
      r_t = (rv === 1'b1);
      @(posedge clk);
      if (a_t) arv <= 1'b0;
    end while (!r_t);
    rr <= 1'b0;
  endtask : rd
  task automatic pulse(input logic [2:0] c, input logic [7:0] w);
    @(posedge clk);
    ch <= c;
    wid <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : pulse
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // Monitor takes the oldest note at every read handshake; it looks at
  // the falling edge, where the answer is settled ahead of its taking edge
  always @(negedge clk) begin
    if (rv === 1'b1 && rr === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("ERROR %0t read answer with no note", $time);
      end else begin
        got_e = exp_q.pop_front();
        `CHK({rresp, rdata}, got_e)
      end
    end
  end
  // Hang guard, well above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h2ffe7061));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h1);
    rd(8'h40, 32'h0, ddi_pkg::DDI_RESP_SLVERR); // Unmapped
    $display("test reset done");
    wr(8'h28, 32'h8); // Slow filter on line 2
    wr(8'h00, 32'h40); // Line 1 inverted
    repeat (20) @(posedge clk);
    rd(8'h04, 32'h2);
    pulse(3'h0, 8'h00);
    pulse(3'h2, 8'h04); // Glitch under the interval
    repeat (20) @(posedge clk);
    rd(8'h04, 32'h3);
    $display("test reflect done");
    wr(8'h00, 32'h0362_1040); // Rise, fall, inverted fall, count
    repeat (20) @(posedge clk);
    rd(8'h04, 32'h3);
    pulse(3'h3, 8'h00);
    pulse(3'h4, 8'h00);
    pulse(3'h5, 8'h00);
    repeat (20) @(posedge clk);
    rd(8'h04, 32'h2B);
    rd(8'h04, 32'h3);
    pulse(3'h3, 8'h00);
    pulse(3'h4, 8'h00);
    repeat (60) @(posedge clk);
    rd(8'h04, 32'h13);
    $display("test edge done");
    rd(8'h08, 32'h38);
    wr(8'h0C, 32'h10);
    #1 `CHK(irq, 1'b1)
    wr(8'h08, 32'h10);
    #1 `CHK(irq, 1'b0)
    rd(8'h08, 32'h28);
    rd(8'h10, 32'h3);
    $display("test irq done");
    wr(8'h2C, 32'h28);
    rd(8'h2C, 32'h28);
    pulse(3'h3, 8'h14);
    repeat (80) @(posedge clk);
    rd(8'h04, 32'h3);
    pulse(3'h3, 8'h32 + 8'($urandom_range(20)));
    repeat (150) @(posedge clk);
    rd(8'h04, 32'hB);
    $display("test interval done");
    repeat (2) @(posedge clk);
    results();
  end
endmodule : tb_top
`default_nettype wire
